// ==== shared/cmp_pkg.sv ====
// constants for the comparator output, change-flag and reference control block
package cmp_pkg;

  // ************************************************************
  // register offsets on the plain register port
  // ************************************************************
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0B; // global and peripheral enables
  localparam logic [7:0] ADDR_FLAG = 8'h0D; // peripheral_flag_reg_b
  localparam logic [7:0] ADDR_DIR = 8'h85; // pin_direction_bits
  localparam logic [7:0] ADDR_IE = 8'h8D; // peripheral_enable_reg_b
  localparam logic [7:0] ADDR_AUX = 8'h97; // cmp_aux_config_reg
  localparam logic [7:0] ADDR_CTRL = 8'h9C; // cmp_control_reg
  localparam logic [7:0] ADDR_VREF = 8'h9D; // vref_control_reg

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int CHG2_BIT = 6; // flag and enable of comparator 2
  localparam int CHG1_BIT = 5; // flag and enable of comparator 1
  localparam int RES2_BIT = 7; // cmp_result_bit of comparator 2
  localparam int RES1_BIT = 6;
  localparam int INV2_BIT = 5;
  localparam int INV1_BIT = 4;
  localparam int CIS_BIT = 3;
  localparam int MODE_MSB = 2;
  localparam int GSS_BIT = 1;
  localparam int SYNC_BIT = 0;
  localparam int DIR1_BIT = 4; // direction bit of cmp1_out_pin
  localparam int DIR2_BIT = 5; // direction bit of cmp2_out_pin
  localparam int VREF_POWER_ENABLE_BIT = 7;
  localparam int VRR_BIT = 5;
  localparam int CODE_MSB = 3;

  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [2:0] MODE_RESET = 3'h0; // comparator reset mode
  localparam logic [2:0] MODE_PIN_OUT = 3'h6; // mode that routes results to pins
  localparam logic GSS_RESET = 1'h1;
  localparam logic SYNC_RESET = 1'h0;
  localparam logic [7:0] DIR_RESET = 8'hFF; // all pins input
  localparam logic [3:0] CODE_ZERO = 4'h0;

  // ladder level in units of supply / 96
  localparam logic [6:0] LOW_RANGE_STEP = 7'h04; // 1/24 = 4/96
  localparam logic [6:0] HIGH_RANGE_BASE = 7'h18; // 1/4 = 24/96
  localparam logic [6:0] HIGH_RANGE_STEP = 7'h03; // 1/32 = 3/96

endpackage : cmp_pkg

// ==== rtl/cmp_output_irq.sv ====
// comparator output status, timer gate select, change flags and reference control
`timescale 1ns/1ps
// ************************************************************
// Behaviour
// - gate select bit picks pin or comparator 2
// - result status bits are read only
// - pin mode routes comparator results to pins
// - direction bits still enable those pin drivers
// - per comparator polarity invert bit
// - sync bit latches comparator 2 on falling edge
// - latch uses prescaled timer clock
// - latch falling edge, timer counts rising edge
// - flag sets on comparator output change
// - software writes 0 clears, 1 sets flag
// - interrupt needs three enables; flags always set
// - control register access captures new reference
// - persisting mismatch keeps setting the flag
// - change during control read still sets the flag
// - reference offers 32 levels in two ranges
// - low range code/24, high quarter plus code/32
// - disabled with code zero ties reference low
// - reset forces mode 000 and reference off
// - comparators run and wake in sleep
// ************************************************************
module cmp_output_irq (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // analog comparator results and pins, asynchronous
  input wire logic [1:0] cmp_raw_i,
  input wire logic external_gate_pin_i,
  // gated timer neighbour: clock after its prescaler
  input wire logic timer_clk_i,
  output logic timer_gate_o,
  // port pins shared with the comparator results
  input wire logic [1:0] port_data_i,
  output logic cmp1_out_pin_o,
  output logic cmp1_out_pin_oe_o,
  output logic cmp2_out_pin_o,
  output logic cmp2_out_pin_oe_o,
  // interrupt and wake
  output logic irq_o,
  output logic wake_o,
  // reference ladder control
  output logic vref_power_enable_o,
  output logic vref_ground_o,
  output logic [6:0] internal_reference_level_o,
  // comparator configuration towards the analog side
  output logic [2:0] cmp_mode_field_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0] cmp_s1; // comparator synchroniser stages
    logic [1:0] cmp_s2;
    logic [1:0] cmp_s3;
    logic [1:0] cmp_lvl; // accepted comparator levels
    logic gate_s1; // gate pin synchroniser
    logic gate_s2;
    logic gate_s3;
    logic gate_lvl;
    logic tclk_s1; // timer clock synchroniser
    logic tclk_s2;
    logic tclk_s3;
    logic tclk_lvl;
    logic [2:0] mode; // cmp_mode_field
    logic cis;
    logic [1:0] inv; // polarity invert bits
    logic gss; // timer_gate_source_sel
    logic sync_en; // cmp2_sync_enable
    logic c2_latch; // comparator 2 captured on timer clock fall
    logic [1:0] ref_val; // outputs captured at last control access
    logic [1:0] flag; // cmp_change_flag
    logic [1:0] ie; // cmp_change_irq_enable
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic [7:0] dir; // pin_direction_bits, 1 = input
    logic vref_power_enable;
    logic vref_range_select;
    logic [3:0] code; // vref_level_code
    logic [7:0] rdata;
    logic gate;
    logic irq;
    logic wake;
    logic [1:0] pin;
    logic [1:0] pin_oe;
    logic [6:0] level;
    logic vgnd;
  } state_t;
  state_t q;
  state_t d;
  // ************************************************************
  // helpers
  // ************************************************************
  // a change counts only once the second and third stage agree
  function automatic logic agree(input logic s2, input logic s3, input logic lvl);
    agree = (s2 == s3) ? s3 : lvl;
  endfunction : agree
  // ladder level in units of supply / 96
  function automatic logic [6:0] ladder(input logic low_rng, input logic [3:0] c);
    logic [6:0] cw;
    cw = {3'h0, c};
    if (low_rng)
      ladder = 7'(cw * cmp_pkg::LOW_RANGE_STEP);
    else
      ladder = 7'(cmp_pkg::HIGH_RANGE_BASE + cw * cmp_pkg::HIGH_RANGE_STEP);
  endfunction : ladder
  // decoded accesses and derived values
  logic [1:0] cmp_out; // polarity-adjusted results
  logic [1:0] mismatch;
  logic ctrl_acc;
  logic tclk_fall;
  logic [1:0] flag_pend;

  always_comb
  begin
    cmp_out = q.cmp_lvl ^ q.inv;
    mismatch = cmp_out ^ q.ref_val;
    // reads and writes alike end the mismatch
    ctrl_acc = (wr_i | rd_i) && (addr_i == cmp_pkg::ADDR_CTRL);
    // falling edge of the prescaled timer clock, after agreement
    tclk_fall = q.tclk_lvl && !agree(q.tclk_s2, q.tclk_s3, q.tclk_lvl);
    flag_pend = q.flag & q.ie;
  end
  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d = q;
    // input synchronisers: first stage read only by the second
    d.cmp_s1 = cmp_raw_i;
    d.cmp_s2 = q.cmp_s1;
    d.cmp_s3 = q.cmp_s2;
    d.cmp_lvl[0] = agree(q.cmp_s2[0], q.cmp_s3[0], q.cmp_lvl[0]);
    d.cmp_lvl[1] = agree(q.cmp_s2[1], q.cmp_s3[1], q.cmp_lvl[1]);
    d.gate_s1 = external_gate_pin_i;
    d.gate_s2 = q.gate_s1;
    d.gate_s3 = q.gate_s2;
    d.gate_lvl = agree(q.gate_s2, q.gate_s3, q.gate_lvl);
    d.tclk_s1 = timer_clk_i;
    d.tclk_s2 = q.tclk_s1;
    d.tclk_s3 = q.tclk_s2;
    d.tclk_lvl = agree(q.tclk_s2, q.tclk_s3, q.tclk_lvl);
    // comparator 2 latch: the timer counts on the rising edge, so
    // sampling on the fall keeps the gate steady across each count
    if (tclk_fall)
      d.c2_latch = cmp_out[1];
    // register writes; result bits and unused aux bits take nothing
    if (wr_i)
    begin
      unique case (addr_i)
        cmp_pkg::ADDR_CTRL:
        begin
          d.inv = {wdata_i[cmp_pkg::INV2_BIT], wdata_i[cmp_pkg::INV1_BIT]};
          d.cis = wdata_i[cmp_pkg::CIS_BIT];
          d.mode = wdata_i[cmp_pkg::MODE_MSB:0];
        end
        cmp_pkg::ADDR_AUX:
        begin
          d.gss = wdata_i[cmp_pkg::GSS_BIT];
          d.sync_en = wdata_i[cmp_pkg::SYNC_BIT];
        end
        cmp_pkg::ADDR_FLAG:
          // zero clears and one sets, as software sees fit
          d.flag = {wdata_i[cmp_pkg::CHG2_BIT], wdata_i[cmp_pkg::CHG1_BIT]};
        cmp_pkg::ADDR_IE:
          d.ie = {wdata_i[cmp_pkg::CHG2_BIT], wdata_i[cmp_pkg::CHG1_BIT]};
        cmp_pkg::ADDR_IRQ_CTRL:
        begin
          d.global_irq_enable = wdata_i[cmp_pkg::GIE_BIT];
          d.peripheral_irq_enable = wdata_i[cmp_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
        end
        cmp_pkg::ADDR_DIR:
          d.dir = wdata_i;
        cmp_pkg::ADDR_VREF:
        begin
          d.vref_power_enable = wdata_i[cmp_pkg::VREF_POWER_ENABLE_BIT];
          d.vref_range_select = wdata_i[cmp_pkg::VRR_BIT];
          d.code = wdata_i[cmp_pkg::CODE_MSB:0];
        end
        default:
          d.rdata = q.rdata; // unmapped writes are dropped
      endcase
    end
    // hardware set wins over a clear in the same cycle, and keeps
    // winning while the mismatch lasts, a control read included;
    // enables never gate the flag
    d.flag = d.flag | mismatch;
    // a control access takes the present results as the reference
    if (ctrl_acc)
      d.ref_val = cmp_out;
    // read data, one cycle after the strobe; zero otherwise
    d.rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        cmp_pkg::ADDR_CTRL:
        begin
          d.rdata[cmp_pkg::RES2_BIT] = cmp_out[1];
          d.rdata[cmp_pkg::RES1_BIT] = cmp_out[0];
          d.rdata[cmp_pkg::INV2_BIT] = q.inv[1];
          d.rdata[cmp_pkg::INV1_BIT] = q.inv[0];
          d.rdata[cmp_pkg::CIS_BIT] = q.cis;
          d.rdata[cmp_pkg::MODE_MSB:0] = q.mode;
        end
        cmp_pkg::ADDR_AUX:
        begin
          d.rdata[cmp_pkg::GSS_BIT] = q.gss;
          d.rdata[cmp_pkg::SYNC_BIT] = q.sync_en;
        end
        cmp_pkg::ADDR_FLAG:
        begin
          d.rdata[cmp_pkg::CHG2_BIT] = q.flag[1];
          d.rdata[cmp_pkg::CHG1_BIT] = q.flag[0];
        end
        cmp_pkg::ADDR_IE:
        begin
          d.rdata[cmp_pkg::CHG2_BIT] = q.ie[1];
          d.rdata[cmp_pkg::CHG1_BIT] = q.ie[0];
        end
        cmp_pkg::ADDR_IRQ_CTRL:
        begin
          d.rdata[cmp_pkg::GIE_BIT] = q.global_irq_enable;
          d.rdata[cmp_pkg::PERIPHERAL_IRQ_ENABLE_BIT] = q.peripheral_irq_enable;
        end
        cmp_pkg::ADDR_DIR:
          d.rdata = q.dir;
        cmp_pkg::ADDR_VREF:
        begin
          d.rdata[cmp_pkg::VREF_POWER_ENABLE_BIT] = q.vref_power_enable;
          d.rdata[cmp_pkg::VRR_BIT] = q.vref_range_select;
          d.rdata[cmp_pkg::CODE_MSB:0] = q.code;
        end
        default:
          d.rdata = 8'h00; // unmapped reads answer zero
      endcase
    end
    // timer gate: pin, or comparator 2 latched or passed straight
    if (q.gss)
      d.gate = q.gate_lvl;
    else if (q.sync_en)
      d.gate = q.c2_latch;
    else
      d.gate = cmp_out[1];
    // interrupt needs all three enables; wake ignores the global one
    d.irq = (|flag_pend) && q.peripheral_irq_enable && q.global_irq_enable;
    d.wake = (|flag_pend) && q.peripheral_irq_enable;
    // pins carry the results in pin mode, port data otherwise;
    // the result path takes one register of the raw input, no synchroniser,
    // so a pin may show a metastable settle like the analog output itself
    if (q.mode == cmp_pkg::MODE_PIN_OUT)
      d.pin = cmp_raw_i ^ q.inv;
    else
      d.pin = port_data_i;
    d.pin_oe = ~{q.dir[cmp_pkg::DIR2_BIT], q.dir[cmp_pkg::DIR1_BIT]};
    // reference ladder; off with code zero means tied to ground
    d.vgnd = !q.vref_power_enable && (q.code == cmp_pkg::CODE_ZERO);
    if (q.vref_power_enable)
      d.level = ladder(q.vref_range_select, q.code);
    else
      d.level = 7'h00;
  end
  // ************************************************************
  // registers
  // ************************************************************
  // synchronous reset; sleep leaves everything running and untouched
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
      q.mode <= cmp_pkg::MODE_RESET;
      q.vref_power_enable <= 1'b0;
      q.gss <= cmp_pkg::GSS_RESET;
      q.sync_en <= cmp_pkg::SYNC_RESET;
      q.dir <= cmp_pkg::DIR_RESET;
      q.vgnd <= 1'b1;
    end
    else
      q <= d;
  end
  // outputs straight from the state
  assign rdata_o = q.rdata;
  assign timer_gate_o = q.gate;
  assign cmp1_out_pin_o = q.pin[0];
  assign cmp2_out_pin_o = q.pin[1];
  assign cmp1_out_pin_oe_o = q.pin_oe[0];
  assign cmp2_out_pin_oe_o = q.pin_oe[1];
  assign irq_o = q.irq;
  assign wake_o = q.wake;
  assign vref_power_enable_o = q.vref_power_enable;
  assign vref_ground_o = q.vgnd;
  assign internal_reference_level_o = q.level;
  assign cmp_mode_field_o = q.mode;
  // ************************************************************
  // assertions
  // ************************************************************
  property p_gate_pin;
    @(posedge clk_i) disable iff (!resetn_i)
    q.gss |=> timer_gate_o == $past(q.gate_lvl);
  endproperty
  a_gate_pin: assert property (p_gate_pin) else $error("gate not from pin");
  property p_result_read;
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == cmp_pkg::ADDR_CTRL) |=> rdata_o[7:6] == $past(cmp_out);
  endproperty
  a_result_read: assert property (p_result_read) else $error("result bits wrong");
  property p_pin_route;
    @(posedge clk_i) disable iff (!resetn_i)
    (q.mode == cmp_pkg::MODE_PIN_OUT) |=> cmp2_out_pin_o == $past(cmp_raw_i[1] ^ q.inv[1]);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin not routed");
  property p_pin_oe;
    @(posedge clk_i) disable iff (!resetn_i)
    ##1 cmp1_out_pin_oe_o == !$past(q.dir[cmp_pkg::DIR1_BIT]);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
  property p_latch_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    !tclk_fall |=> $stable(q.c2_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved off edge");
  property p_flag_set;
    @(posedge clk_i) disable iff (!resetn_i)
    mismatch[0] |=> q.flag[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("change flag missed");
  property p_soft_set;
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_i && addr_i == cmp_pkg::ADDR_FLAG && wdata_i[cmp_pkg::CHG2_BIT]) |=> q.flag[1];
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("soft set lost");
  property p_irq_gate;
    @(posedge clk_i) disable iff (!resetn_i)
    irq_o |-> $past(q.global_irq_enable) && $past(q.peripheral_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
  property p_ref_capture;
    @(posedge clk_i) disable iff (!resetn_i)
    ctrl_acc |=> q.ref_val == $past(cmp_out) ##1 1'b1;
  endproperty
  a_ref_capture: assert property (p_ref_capture) else $error("reference not taken");
  property p_vref_ground;
    @(posedge clk_i) disable iff (!resetn_i)
    (!q.vref_power_enable && q.code == cmp_pkg::CODE_ZERO) |=>
      vref_ground_o && internal_reference_level_o == 7'h00;
  endproperty
  a_vref_ground: assert property (p_vref_ground) else $error("reference not grounded");
  property p_reset_state;
    @(posedge clk_i)
    !resetn_i |=> cmp_mode_field_o == cmp_pkg::MODE_RESET && !vref_power_enable_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule : cmp_output_irq

// ==== tb/timer_partner.sv ====
// gated timer neighbour and the two shared port pads seen from outside
`timescale 1ns/1ps
module timer_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // timer control from the bench and gate from the block
  input wire logic run_i,
  input wire logic gate_i,
  output logic timer_clk_o,
  output logic [15:0] count_o,
  // pin drivers from the block
  input wire logic [1:0] pin_i,
  input wire logic [1:0] pin_oe_i,
  output logic [1:0] pad_o
);
  // ************************************************************
  // prescaler and counter
  // ************************************************************
  logic [2:0] div_q = 3'h0; // prescaler; stands still while not running
  logic flip_q = 1'b0; // pattern for an undriven pad
  // prescaled clock is the top divider bit, eight system cycles a period
  always_ff @(posedge clk_i)
  begin
    flip_q <= ~flip_q;
    if (run_i)
    begin
      div_q <= div_q + 3'h1;
    end
  end
  assign timer_clk_o = div_q[2];
  // counting on the rising edge keeps clear of the falling-edge latch
  always_ff @(posedge timer_clk_o or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count_o <= 16'h0000;
    end
    else if (gate_i)
    begin
      count_o <= count_o + 16'h0001;
    end
  end
  // ************************************************************
  // pads: an undriven pad has no pull, so it wanders every cycle
  // ************************************************************
  assign pad_o[0] = pin_oe_i[0] ? pin_i[0] : flip_q;
  assign pad_o[1] = pin_oe_i[1] ? pin_i[1] : ~flip_q;
endmodule : timer_partner

// ==== tb/testbench.sv ====
// self-checking bench for the comparator status, change flag and reference block
`timescale 1ns/1ps
module testbench;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] cmp_raw_i = 2'h0;
  logic ext_pin = 1'b0;
  logic [1:0] port_data_i = 2'h0;
  logic run = 1'b0;
  logic [7:0] rdata_o;
  logic timer_clk, gate, p1, p1_oe, p2, p2_oe, irq, wake, vpwr, vgnd;
  logic [1:0] pad;
  logic [6:0] level;
  logic [2:0] mode;
  logic [15:0] count;
  int miscompares = 0;
  int checked = 0;
  // 125 MHz system clock
  always #4 clk_i = ~clk_i;
  cmp_output_irq cmp_output_irq_i (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_raw_i(cmp_raw_i),
    .external_gate_pin_i(ext_pin), .timer_clk_i(timer_clk), .timer_gate_o(gate),
    .port_data_i(port_data_i), .cmp1_out_pin_o(p1), .cmp1_out_pin_oe_o(p1_oe),
    .cmp2_out_pin_o(p2), .cmp2_out_pin_oe_o(p2_oe), .irq_o(irq), .wake_o(wake),
    .vref_power_enable_o(vpwr), .vref_ground_o(vgnd), .internal_reference_level_o(level),
    .cmp_mode_field_o(mode));
  timer_partner timer_partner_i (.clk_i(clk_i), .resetn_i(resetn_i), .run_i(run),
    .gate_i(gate), .timer_clk_o(timer_clk), .count_o(count), .pin_i({p2, p1}),
    .pin_oe_i({p2_oe, p1_oe}), .pad_o(pad));
  // ************************************************************
  // bus cycles, waits and comparisons
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_n
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic reset_values;
    logic [7:0] d;
    rd(cmp_pkg::ADDR_AUX, d);
    chk8(d, 8'h02);
    rd(cmp_pkg::ADDR_CTRL, d);
    chk8(d, 8'h00);
    rd(cmp_pkg::ADDR_VREF, d);
    chk8(d, 8'h00);
    rd(8'h40, d);
    chk8(d, 8'h00);
    chk1(vpwr, 1'b0);
    chk1(vgnd, 1'b1);
    chk8({5'h00, mode}, 8'h00);
    chk1(p1_oe, 1'b0);
  endtask : reset_values
  task automatic aux_bits;
    logic [7:0] d;
    wr(cmp_pkg::ADDR_AUX, 8'hFF);
    rd(cmp_pkg::ADDR_AUX, d);
    chk8(d, 8'h03);
    wr(cmp_pkg::ADDR_AUX, 8'h02);
  endtask : aux_bits
  // result bits follow the comparators and ignore writes
  task automatic status_bits;
    logic [7:0] d;
    @(posedge clk_i) cmp_raw_i <= 2'b01;
    wait_n(8);
    rd(cmp_pkg::ADDR_CTRL, d);
    chk8(d, 8'h40);
    wr(cmp_pkg::ADDR_CTRL, 8'h80);
    rd(cmp_pkg::ADDR_CTRL, d);
    chk8(d, 8'h40);
    wr(cmp_pkg::ADDR_CTRL, 8'h30);
    wait_n(4);
    rd(cmp_pkg::ADDR_CTRL, d);
    chk8(d, 8'hB0);
    wr(cmp_pkg::ADDR_CTRL, 8'h00);
  endtask : status_bits
  // change flag, sticky mismatch, soft set and the enable chain
  task automatic flags;
    logic [7:0] d;
    wait_n(4);
    rd(cmp_pkg::ADDR_CTRL, d);
    wr(cmp_pkg::ADDR_FLAG, 8'h00);
    rd(cmp_pkg::ADDR_FLAG, d);
    chk8(d & 8'h60, 8'h00);
    @(posedge clk_i) cmp_raw_i <= 2'b00;
    wait_n(8);
    rd(cmp_pkg::ADDR_FLAG, d);
    chk8(d & 8'h60, 8'h20);
    chk1(irq, 1'b0);
    wr(cmp_pkg::ADDR_FLAG, 8'h00);
    rd(cmp_pkg::ADDR_FLAG, d);
    chk8(d & 8'h60, 8'h20);
    rd(cmp_pkg::ADDR_CTRL, d);
    wr(cmp_pkg::ADDR_FLAG, 8'h00);
    rd(cmp_pkg::ADDR_FLAG, d);
    chk8(d & 8'h60, 8'h00);
    wr(cmp_pkg::ADDR_FLAG, 8'h60);
    rd(cmp_pkg::ADDR_FLAG, d);
    chk8(d & 8'h60, 8'h60);
    wr(cmp_pkg::ADDR_IE, 8'h60);
    wr(cmp_pkg::ADDR_IRQ_CTRL, 8'h40);
    wait_n(3);
    chk1(irq, 1'b0);
    chk1(wake, 1'b1);
    wr(cmp_pkg::ADDR_IRQ_CTRL, 8'hC0);
    wait_n(3);
    chk1(irq, 1'b1);
    wr(cmp_pkg::ADDR_FLAG, 8'h00);
    wait_n(3);
    chk1(irq, 1'b0);
    wr(cmp_pkg::ADDR_IRQ_CTRL, 8'h00);
    wr(cmp_pkg::ADDR_IE, 8'h00);
  endtask : flags
  // gate source select and the falling-edge latch of comparator 2
  task automatic gate_paths;
    logic [15:0] c0;
    // three synchroniser stages, agreement, then the gate register
    @(posedge clk_i) ext_pin <= 1'b1;
    wait_n(6);
    chk1(gate, 1'b1);
    @(posedge clk_i) ext_pin <= 1'b0;
    wait_n(6);
    chk1(gate, 1'b0);
    @(posedge clk_i) cmp_raw_i <= 2'b10;
    wr(cmp_pkg::ADDR_AUX, 8'h00);
    wait_n(8);
    chk1(gate, 1'b1);
    // software keeps comparator 2 synchronised while it gates the timer
    wr(cmp_pkg::ADDR_AUX, 8'h01);
    @(posedge clk_i) run <= 1'b1;
    wait_n(40);
    chk1(gate, 1'b1);
    c0 = count;
    wait_n(16);
    chk1(count != c0, 1'b1);
    @(posedge clk_i) run <= 1'b0;
    @(posedge clk_i) cmp_raw_i <= 2'b00;
    wait_n(16);
    chk1(gate, 1'b1);
    @(posedge clk_i) run <= 1'b1;
    wait_n(24);
    chk1(gate, 1'b0);
    @(posedge clk_i) run <= 1'b0;
    wr(cmp_pkg::ADDR_AUX, 8'h02);
  endtask : gate_paths
  // comparator results on the pins, direction bits as enables
  task automatic pin_route;
    @(posedge clk_i) cmp_raw_i <= 2'b01;
    @(posedge clk_i) port_data_i <= 2'b10;
    wr(cmp_pkg::ADDR_DIR, 8'hEF);
    wr(cmp_pkg::ADDR_CTRL, 8'h06);
    wait_n(6);
    chk8({5'h00, mode}, 8'h06);
    chk1(p1, 1'b1);
    chk1(pad[0], 1'b1);
    chk1(p1_oe, 1'b1);
    chk1(p2_oe, 1'b0);
    wr(cmp_pkg::ADDR_DIR, 8'hCF);
    wait_n(3);
    chk1(p2_oe, 1'b1);
    chk1(pad[1], 1'b0);
    wr(cmp_pkg::ADDR_CTRL, 8'h26);
    wait_n(4);
    chk1(p2, 1'b1);
    wr(cmp_pkg::ADDR_CTRL, 8'h00);
    wait_n(4);
    chk1(p1, 1'b0);
    chk1(p2, 1'b1);
    wr(cmp_pkg::ADDR_DIR, 8'hFF);
  endtask : pin_route
  // every ladder code in both ranges, in supply/96 units
  task automatic vref_table;
    logic [7:0] d;
    logic [7:0] exp;
    for (int r = 0; r < 2; r++)
    begin
      for (int c = 0; c < 16; c++)
      begin
        wr(cmp_pkg::ADDR_VREF, {2'b10, r[0], 1'b0, c[3:0]});
        wait_n(3);
        exp = (r == 1) ? 8'(c * 4) : 8'(24 + c * 3);
        chk8({1'b0, level}, exp);
      end
    end
    rd(cmp_pkg::ADDR_VREF, d);
    chk8(d, 8'hAF);
    wr(cmp_pkg::ADDR_VREF, 8'h00);
    wait_n(3);
    chk1(vgnd, 1'b1);
    chk8({1'b0, level}, 8'h00);
    wr(cmp_pkg::ADDR_VREF, 8'h03);
    wait_n(3);
    chk1(vgnd, 1'b0);
    wr(cmp_pkg::ADDR_VREF, 8'h80);
    wait_n(3);
    chk1(vgnd, 1'b0);
    chk1(vpwr, 1'b1);
  endtask : vref_table
  // a second reset in mid-run drops mode and reference
  task automatic mid_reset;
    wr(cmp_pkg::ADDR_CTRL, 8'h06);
    @(posedge clk_i) resetn_i <= 1'b0;
    wait_n(3);
    @(posedge clk_i) resetn_i <= 1'b1;
    wait_n(2);
    chk8({5'h00, mode}, 8'h00);
    chk1(vpwr, 1'b0);
  endtask : mid_reset
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_n(6);
    reset_values();
    aux_bits();
    status_bits();
    flags();
    gate_paths();
    pin_route();
    vref_table();
    mid_reset();
    close_out();
  end
  // the whole run needs a few hundred cycles; this is a generous bound
  initial
  begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule : testbench
